// ---- verif/pib_checker_sva.sv ----
module pib_checker_sva
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        cycle_steal_request,
    input wire logic        cycle_steal_grant,
    input wire logic        priority_chain_out_n,
    input wire logic        irq_request,
    input wire logic        extended_addr_oe_n,
    input wire logic        vector_oe_n,
    input wire logic        bus_ctrl_one_oe_n,
    input wire logic        bus_ctrl_two_oe_n,
    input wire logic        mem_ref,
    input wire logic [11:0] mem_addr,
    input wire logic        indirect_call_phase,
    input wire logic        sdma_suspend
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********
    // Pin rules
    // ********
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    steal_req_off_a: assert property
        (!cycle_steal_request)
        else $error("steal request raised");
    chain_level_a: assert property
        (priority_chain_out_n == !irq_request)
        else $error("chain out disagrees with request");
    // Three cycles covers the two-stage input synchroniser
    grant_release_a: assert property
        (cycle_steal_grant [*3] |-> extended_addr_oe_n && vector_oe_n
            && bus_ctrl_one_oe_n && bus_ctrl_two_oe_n)
        else $error("bus held during steal grant");
    grant_return_a: assert property
        ((!cycle_steal_grant) [*3] |-> !extended_addr_oe_n)
        else $error("extended address not driven");
    zero_suspend_a: assert property
        (mem_ref && mem_addr == 12'h000 |-> ##[2:4] sdma_suspend)
        else $error("no suspend on location zero");
    call_suspend_a: assert property
        (indirect_call_phase |-> ##[2:4] sdma_suspend)
        else $error("no suspend on indirect call");
    vector_ctrl_a: assert property
        (!vector_oe_n |-> !bus_ctrl_one_oe_n && !bus_ctrl_two_oe_n)
        else $error("control lines idle with vector");
    vector_cause_a: assert property
        ($fell(vector_oe_n) |-> irq_request)
        else $error("vector without request");

    cover property ($fell(vector_oe_n));
    cover property ($rose(sdma_suspend));
    cover property ($fell(priority_chain_out_n));
endmodule : pib_checker_sva

// ---- verif/pib_host.sv ----
module pib_host
(
    input  wire logic        clock,
    input  wire logic        skip_irq_line_n,
    input  wire logic [11:0] vector_out,
    input  wire logic        vector_oe_n,
    output logic             io_transfer_phase,
    output logic             transfer_control,
    output logic      [4:0]  io_dev_code,
    output logic      [2:0]  io_opcode,
    output logic             irq_grant,
    output logic             cycle_steal_grant,
    output logic      [11:0] mem_addr,
    output logic             mem_ref,
    output logic             indirect_call_phase,
    output logic             field_transfer,
    output logic      [11:0] clock_count,
    output logic             downstream_skip_irq_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        sawSkip;
    logic [11:0] vecSeen;

    // ********
    // Host cycles
    // ********
    initial
    begin
        {io_transfer_phase, transfer_control, io_dev_code, io_opcode,
         irq_grant, cycle_steal_grant, mem_addr, mem_ref,
         indirect_call_phase, field_transfer, clock_count} = '0;
        // Pulled-up input: idle reads high
        downstream_skip_irq_n = 1'b1;
    end

    // Zero vector means none was seen; the bench never programs zero
    task automatic io_transfer_instruction(input logic [4:0] dev, input logic [2:0] op);
        sawSkip = 1'b0;
        vecSeen = 12'h000;
        @(posedge clock);
        {io_dev_code, io_opcode, io_transfer_phase} <= {dev, op, 1'b1};
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clock);
            transfer_control <= (i > 0 && i < 6);
            sawSkip = sawSkip | (skip_irq_line_n === 1'b0);
            if (vector_oe_n === 1'b0)
                vecSeen = vector_out;
            if (i == 7)
                {io_transfer_phase, irq_grant} <= 2'b00;
        end
    endtask : io_transfer_instruction

    task automatic overflow();
        @(posedge clock);
        clock_count <= 12'h800;
        repeat (4) @(posedge clock);
        clock_count <= 12'h000;
        repeat (4) @(posedge clock);
    endtask : overflow

    task automatic touch(input logic [11:0] a, input logic call);
        @(posedge clock);
        {mem_addr, mem_ref, indirect_call_phase} <= {a, ~call, call};
        @(posedge clock);
        {mem_ref, indirect_call_phase} <= 2'b00;
    endtask : touch
endmodule : pib_host

// ---- verif/tb.sv ----
module tb
    import pib_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, rst, psel, penable, pwrite, pready, pslverr, erv;
    logic [11:0] paddr, mem_addr, clock_count, vector_out;
    logic [31:0] pwdata, prdata, rdv;
    logic        io_transfer_phase, transfer_control, irq_grant, mem_ref;
    logic        cycle_steal_grant, indirect_call_phase, field_transfer;
    logic        downstream_skip_irq_n, cycle_steal_request, vector_oe_n;
    logic        skip_irq_line_n, priority_chain_out_n, sdma_suspend;
    logic        extended_addr_oe_n;
    logic [2:0]  extended_addr_out;
    logic [5:0]  saved_fields;
    logic [4:0]  io_dev_code;
    logic [2:0]  io_opcode;
    int          err_total, comparisons;

    pib_priority_interrupt_bus_share u_pib_priority_interrupt_bus_share
    (
        .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .io_transfer_phase, .transfer_control,
        .io_dev_code, .io_opcode, .irq_grant, .cycle_steal_grant,
        .mem_addr, .mem_ref, .indirect_call_phase, .field_transfer,
        .clock_count, .downstream_skip_irq_n, .cycle_steal_request,
        .skip_irq_line_n, .priority_chain_out_n, .irq_request(),
        .vector_out, .vector_oe_n, .bus_ctrl_one_o(), .bus_ctrl_one_oe_n(),
        .bus_ctrl_two_o(), .bus_ctrl_two_oe_n(), .extended_addr_out,
        .extended_addr_oe_n, .sdma_suspend, .instr_field(),
        .instr_buffer_field(), .data_field(), .saved_fields
    );
    pib_host u_pib_host
    (
        .clock, .skip_irq_line_n, .vector_out, .vector_oe_n,
        .io_transfer_phase, .transfer_control, .io_dev_code, .io_opcode,
        .irq_grant, .cycle_steal_grant, .mem_addr, .mem_ref,
        .indirect_call_phase, .field_transfer, .clock_count,
        .downstream_skip_irq_n
    );

    // ********
    // Helpers
    // ********
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic end_sim();
        if (err_total == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    task automatic st(input int n);
        repeat (n) @(posedge clock);
    endtask : st

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        erv = pslverr;
        {psel, penable} <= 2'b00;
        if (pready !== 1'b1)
        begin
            err_total++;
            end_sim();
        end
        else
            @(posedge clock);
    endtask : apb

    task automatic sus(input logic exp);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clock);
            hit = hit | (sdma_suspend === 1'b1);
        end
        chk("suspend", hit, exp);
    endtask : sus

    // ********
    // Scenarios
    // ********
    task automatic t_reset();
        chk("chain", priority_chain_out_n, 32'h1);
        chk("steal", cycle_steal_request, 32'h0);
        chk("vector", vector_out, 32'h20);
        apb(1'b1, ADDR_CTRL, 32'h3);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl", rdv, 32'h3);
        apb(1'b0, 12'h018, 32'h0);
        chk("slverr", erv, 32'h1);
    endtask : t_reset

    task automatic t_dma();
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b1, ADDR_EVENT, 32'h2);
        chk("chain", priority_chain_out_n, 32'h0);
        chk("skip", skip_irq_line_n, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h5);
        chk("skip", skip_irq_line_n, 32'h1);
        u_pib_host.field_transfer <= 1'b1;
        st(1);
        u_pib_host.field_transfer <= 1'b0;
        st(5);
        chk("skip", skip_irq_line_n, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_EVENT, 32'h4);
        chk("chain", priority_chain_out_n, 32'h1);
        apb(1'b1, ADDR_EVENT, 32'h20);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", rdv, 32'h0);
    endtask : t_dma

    task automatic t_clock();
        apb(1'b1, ADDR_CTRL, 32'h6);
        u_pib_host.overflow();
        chk("chain", priority_chain_out_n, 32'h0);
        chk("skip", skip_irq_line_n, 32'h1);
        u_pib_host.io_transfer_instruction(5'h08, 3'h1);
        chk("clkskip", u_pib_host.sawSkip, 32'h1);
        u_pib_host.io_transfer_instruction(5'h0a, 3'h1);
        chk("foreign", u_pib_host.sawSkip, 32'h0);
        u_pib_host.io_transfer_instruction(5'h05, 3'h1);
        chk("wofskip", u_pib_host.sawSkip, 32'h0);
        u_pib_host.io_transfer_instruction(5'h08, 3'h5);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", rdv, 32'h10);
    endtask : t_clock

    task automatic t_vector();
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b1, ADDR_VECTOR, 32'h40);
        apb(1'b1, ADDR_FIELDS, 32'h1d);
        u_pib_host.field_transfer <= 1'b1;
        st(1);
        u_pib_host.field_transfer <= 1'b0;
        st(5);
        chk("ifield", extended_addr_out, 32'h5);
        apb(1'b1, ADDR_EVENT, 32'h4);
        u_pib_host.io_transfer_instruction(5'h09, 3'h0);
        chk("novec", u_pib_host.vecSeen, 32'h0);
        chk("reqskip", u_pib_host.sawSkip, 32'h1);
        for (int k = 0; k < 2; k++)
        begin
            u_pib_host.irq_grant <= 1'b1;
            st(5);
            chk("saved", saved_fields, k ? 32'h0 : 32'h2b);
            u_pib_host.io_transfer_instruction(5'h09, 3'h0);
            chk("vec", u_pib_host.vecSeen, 32'h41 - k);
            u_pib_host.overflow();
        end
        apb(1'b0, ADDR_FIELDS, 32'h0);
        chk("fields", rdv, 32'h0);
        chk("ifield", extended_addr_out, 32'h0);
        apb(1'b1, ADDR_EVENT, 32'h20);
    endtask : t_vector

    task automatic t_bus();
        u_pib_host.cycle_steal_grant <= 1'b1;
        st(5);
        chk("eaoe", extended_addr_oe_n, 32'h1);
        u_pib_host.cycle_steal_grant <= 1'b0;
        u_pib_host.touch(12'h000, 1'b0);
        sus(1'b1);
        u_pib_host.touch(12'h123, 1'b0);
        sus(1'b0);
        u_pib_host.touch(12'h123, 1'b1);
        sus(1'b1);
        u_pib_host.downstream_skip_irq_n <= 1'b0;
        st(5);
        chk("dskip", skip_irq_line_n, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h4);
        chk("dinh", skip_irq_line_n, 32'h1);
        u_pib_host.downstream_skip_irq_n <= 1'b1;
    endtask : t_bus

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        err_total = 0;
        comparisons = 0;
        rst = 1'b1;
        st(12);
        rst <= 1'b0;
        st(1);
        t_reset();
        t_dma();
        t_clock();
        t_vector();
        t_bus();
        end_sim();
    end
endmodule : tb

bind pib_priority_interrupt_bus_share pib_checker_sva u_pib_checker_sva
(
    .clock, .rst, .cycle_steal_request, .cycle_steal_grant,
    .priority_chain_out_n, .irq_request, .extended_addr_oe_n,
    .vector_oe_n, .bus_ctrl_one_oe_n, .bus_ctrl_two_oe_n, .mem_ref,
    .mem_addr, .indirect_call_phase, .sdma_suspend
);

// ---- verilog/pib_pkg.sv ----
package pib_pkg;

    // *********************************************************
    // Register map (byte addresses)
    // *********************************************************
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_EVENT  = 12'h008;
    localparam logic [11:0] ADDR_VECTOR = 12'h00c;
    localparam logic [11:0] ADDR_FIELDS = 12'h010;

    // *********************************************************
    // Field positions
    // *********************************************************
    // Control register
    localparam int CTRL_DMA_IEN   = 0;
    localparam int CTRL_CLK_IEN   = 1;
    localparam int CTRL_INHIBIT   = 2;
    // Event register (write one to act)
    localparam int EV_SET_COF     = 0;
    localparam int EV_SET_FWE     = 1;
    localparam int EV_SET_WOF     = 2;
    localparam int EV_CLR_FWE     = 3;
    localparam int EV_CLR_WOF     = 4;
    localparam int EV_CLR_ALL     = 5;
    // Status register
    localparam int ST_COF         = 0;
    localparam int ST_FWE         = 1;
    localparam int ST_WOF         = 2;
    localparam int ST_REQ         = 3;
    localparam int ST_INHIBIT     = 4;
    localparam int ST_DMA_SUSP    = 5;
    // Field register: buffer field and data field, three bits each
    localparam int FLD_IB         = 0;
    localparam int FLD_DF         = 3;

    // *********************************************************
    // Reset values and constants
    // *********************************************************
    localparam logic [2:0]  CTRL_RESET   = 3'h0;
    localparam logic [11:0] VECTOR_RESET = 12'h020;
    localparam logic [11:0] IRQ_ENTRY    = 12'h001;
    localparam logic [2:0]  FIELD_ZERO   = 3'h0;
    localparam logic [11:0] LOC_ZERO     = 12'h000;
    localparam int          CLK_MSB      = 11;

    // Device-select codes this device answers (instr bits 3..7)
    localparam logic [4:0] DEVICE_SELECTED_A = 5'h05;
    localparam logic [4:0] DEVICE_SELECTED_B = 5'h08;
    localparam logic [4:0] DEVICE_SELECTED_C = 5'h09;
    localparam logic [4:0] DEVICE_SELECTED_D = 5'h0b;

    typedef enum logic [1:0]
    {
        PIB_IDLE  = 2'b00,
        PIB_ARMED = 2'b01,
        PIB_VECT  = 2'b11
    } pib_vec_e;

endpackage : pib_pkg

// ---- verilog/pib_priority_interrupt_bus_share.sv ----
module pib_priority_interrupt_bus_share
    import pib_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Host processor pins
    input  wire logic        io_transfer_phase,
    input  wire logic        transfer_control,
    input  wire logic [4:0]  io_dev_code,
    input  wire logic [2:0]  io_opcode,
    input  wire logic        irq_grant,
    input  wire logic        cycle_steal_grant,
    input  wire logic [11:0] mem_addr,
    input  wire logic        mem_ref,
    input  wire logic        indirect_call_phase,
    input  wire logic        field_transfer,
    input  wire logic [11:0] clock_count,
    input  wire logic        downstream_skip_irq_n,
    output logic             cycle_steal_request,
    output logic             skip_irq_line_n,
    output logic             priority_chain_out_n,
    output logic             irq_request,
    output logic      [11:0] vector_out,
    output logic             vector_oe_n,
    output logic             bus_ctrl_one_o,
    output logic             bus_ctrl_one_oe_n,
    output logic             bus_ctrl_two_o,
    output logic             bus_ctrl_two_oe_n,
    output logic      [2:0]  extended_addr_out,
    output logic             extended_addr_oe_n,
    output logic             sdma_suspend,
    output logic      [2:0]  instr_field,
    output logic      [2:0]  instr_buffer_field,
    output logic      [2:0]  data_field,
    output logic      [5:0]  saved_fields
);
    import pib_pkg::*;

    // *********************************************************
    // Pin synchronisers
    // *********************************************************
    localparam int NSYNC = 36;
    logic [NSYNC-1:0] rawPins;
    logic [NSYNC-1:0] syncPins;
    assign rawPins = {io_transfer_phase, transfer_control, io_dev_code,
                      io_opcode, irq_grant, cycle_steal_grant, mem_addr,
                      mem_ref, indirect_call_phase, field_transfer,
                      clock_count[CLK_MSB], downstream_skip_irq_n,
                      7'h00};

    pib_sync #(.W(NSYNC), .INIT(36'h0)) u_sync
    (
        .clock (clock),
        .rst   (rst),
        .din   (rawPins),
        .dout  (syncPins)
    );

    wire        ioPhase   = syncPins[35];
    wire        xferCtl   = syncPins[34];
    wire [4:0]  devCode   = syncPins[33:29];
    wire [2:0]  opcode    = syncPins[28:26];
    wire        grant     = syncPins[25];
    wire        csGrant   = syncPins[24];
    wire [11:0] memAddr   = syncPins[23:12];
    wire        memRef    = syncPins[11];
    wire        jmsInd    = syncPins[10];
    wire        ibToIf    = syncPins[9];
    wire        cntMsb    = syncPins[8];
    // Downstream pull-up: a reset value of 0 would read as a request,
    // so the chain input is qualified until the pipe has filled
    wire        dsReqRaw  = ~syncPins[7];

    // *********************************************************
    // APB decode
    // *********************************************************
    logic [2:0] ctrl;
    logic       clock_overflow_flag;
    logic       fwe;
    logic       word_count_overflow_flag;
    logic       inhibit;
    logic       cntMsbD;
    logic       syncReady;
    logic [1:0] fillCnt;
    logic [11:0] vectorBase;
    pib_vec_e   vecState;
    pib_vec_e   next_vecState;

    wire access   = psel & penable;
    wire wrEn     = access & pwrite;
    wire rdEn     = access & ~pwrite;
    wire hitCtrl  = paddr == ADDR_CTRL;
    wire hitStat  = paddr == ADDR_STATUS;
    wire hitEvent = paddr == ADDR_EVENT;
    wire hitVec   = paddr == ADDR_VECTOR;
    wire hitField = paddr == ADDR_FIELDS;
    wire mapped   = hitCtrl | hitStat | hitEvent | hitVec | hitField;
    wire evWr     = wrEn & hitEvent;

    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // *********************************************************
    // Host instruction decode
    // *********************************************************
    wire selected = ioPhase & ((devCode == DEVICE_SELECTED_A) | (devCode == DEVICE_SELECTED_B)
                  | (devCode == DEVICE_SELECTED_C) | (devCode == DEVICE_SELECTED_D));
    // Clock status read: select code B, opcode 5
    wire clkStatusRd = selected & xferCtl & (devCode == DEVICE_SELECTED_B)
                     & (opcode == 3'h5);
    wire clkStatusRdD;
    logic clkStatusRdQ;
    assign clkStatusRdD = clkStatusRd & ~clkStatusRdQ;
    wire skipClk  = selected & xferCtl & (devCode == DEVICE_SELECTED_B)
                  & (opcode == 3'h1);
    wire skipWof  = selected & xferCtl & (devCode == DEVICE_SELECTED_A)
                  & (opcode == 3'h1);
    wire skipTrue = (skipClk & clock_overflow_flag & ctrl[CTRL_CLK_IEN])
                  | (skipWof & word_count_overflow_flag);

    // *********************************************************
    // Flags
    // *********************************************************
    wire cofEvent = cntMsbD & ~cntMsb;
    wire setCof   = cofEvent | (evWr & pwdata[EV_SET_COF]);
    wire setFwe   = evWr & pwdata[EV_SET_FWE];
    wire setWof   = evWr & pwdata[EV_SET_WOF];
    wire clrAll   = evWr & pwdata[EV_CLR_ALL];
    // Set wins over clear
    wire next_cof = setCof | (clock_overflow_flag & ~clrAll & ~clkStatusRdD);
    wire next_fwe = setFwe | (fwe & ~clrAll & ~(evWr & pwdata[EV_CLR_FWE]));
    wire next_wof = setWof | (word_count_overflow_flag & ~clrAll & ~(evWr & pwdata[EV_CLR_WOF]));

    // Device request: enable-gated flags, clock overflow flag included
    wire devReq = (ctrl[CTRL_CLK_IEN] & clock_overflow_flag)
                | (ctrl[CTRL_DMA_IEN] & (fwe | word_count_overflow_flag));
    wire dsReq  = dsReqRaw & syncReady;
    wire anyReq = (devReq | dsReq) & ~inhibit;

    // *********************************************************
    // Chain and skip line
    // *********************************************************
    assign priority_chain_out_n = ~devReq;
    assign irq_request          = devReq;
    assign skip_irq_line_n = ~(anyReq | skipTrue);
    assign cycle_steal_request  = 1'b0;

    // *********************************************************
    // Vectoring
    // *********************************************************
    // Grant tied low never arms the vector path, requests still flow
    wire vecCycle = (vecState == PIB_ARMED) & ioPhase & grant
                  & devReq;

    always_comb
    begin
        next_vecState = vecState;
        case (vecState)
            PIB_IDLE:  if (grant) next_vecState = PIB_ARMED;
            PIB_ARMED: if (!grant) next_vecState = PIB_IDLE;
                       else if (vecCycle) next_vecState = PIB_VECT;
            PIB_VECT:  if (!ioPhase) next_vecState = PIB_IDLE;
            default:   next_vecState = PIB_IDLE;
        endcase
    end

    wire driveVec = (vecState == PIB_VECT) & ~csGrant;
    assign vector_oe_n        = ~driveVec;
    assign bus_ctrl_one_o     = 1'b0;
    assign bus_ctrl_two_o     = 1'b0;
    assign bus_ctrl_one_oe_n  = ~driveVec;
    assign bus_ctrl_two_oe_n  = ~driveVec;
    assign extended_addr_oe_n = csGrant;
    assign extended_addr_out  = instr_field;

    // Location-zero reference or indirect call phase
    wire next_susp = (memRef & (memAddr == LOC_ZERO))
                   | jmsInd;

    wire grantRise;
    logic grantD;
    assign grantRise = grant & ~grantD;

    // *********************************************************
    // Registers
    // *********************************************************
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ctrl         <= CTRL_RESET;
            clock_overflow_flag          <= 1'b0;
            fwe          <= 1'b0;
            word_count_overflow_flag          <= 1'b0;
            inhibit      <= 1'b0;
            cntMsbD      <= 1'b0;
            clkStatusRdQ <= 1'b0;
            fillCnt      <= 2'h0;
            syncReady    <= 1'b0;
            vecState     <= PIB_IDLE;
            vectorBase   <= VECTOR_RESET;
            vector_out   <= VECTOR_RESET;
            sdma_suspend <= 1'b0;
            grantD       <= 1'b0;
        end
        else
        begin
            if (wrEn && hitCtrl)
                ctrl <= pwdata[2:0];
            if (wrEn && hitVec)
                vectorBase <= pwdata[11:0];
            clock_overflow_flag          <= next_cof;
            fwe          <= next_fwe;
            word_count_overflow_flag          <= next_wof;
            cntMsbD      <= cntMsb;
            clkStatusRdQ <= clkStatusRd;
            fillCnt      <= (fillCnt == 2'h3) ? fillCnt : fillCnt + 2'h1;
            syncReady    <= fillCnt == 2'h3;
            vecState     <= next_vecState;
            // Software sets inhibit; a field transfer clears it
            if (ibToIf)
                inhibit <= 1'b0;
            else if (wrEn && hitCtrl)
                inhibit <= pwdata[CTRL_INHIBIT];
            if (vecCycle)
                vector_out <= {vectorBase[11:1], ~clock_overflow_flag};
            sdma_suspend <= next_susp;
            grantD       <= grant;
        end
    end

    // *********************************************************
    // Memory fields
    // *********************************************************
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            instr_field        <= FIELD_ZERO;
            instr_buffer_field <= FIELD_ZERO;
            data_field         <= FIELD_ZERO;
            saved_fields       <= 6'h00;
        end
        else if (grantRise)
        begin
            saved_fields       <= {instr_buffer_field, data_field};
            instr_field        <= FIELD_ZERO;
            instr_buffer_field <= FIELD_ZERO;
            data_field         <= FIELD_ZERO;
        end
        else
        begin
            // A field write landing on a grant edge is lost: the grant wins
            if (wrEn && hitField)
            begin
                instr_buffer_field <= pwdata[FLD_IB +: 3];
                data_field         <= pwdata[FLD_DF +: 3];
            end
            if (ibToIf)
                instr_field <= instr_buffer_field;
        end
    end

    // *********************************************************
    // Read mux
    // *********************************************************
    wire [31:0] statusWord = {26'h0, sdma_suspend, inhibit, devReq,
                              word_count_overflow_flag, fwe, clock_overflow_flag};
    assign prdata = !rdEn    ? 32'h0 :
                    hitCtrl  ? {29'h0, inhibit, ctrl[1:0]} :
                    hitStat  ? statusWord :
                    hitVec   ? {20'h0, vectorBase} :
                    hitField ? {26'h0, data_field, instr_buffer_field} :
                    32'h0;
endmodule : pib_priority_interrupt_bus_share

// ---- verilog/pib_sync.sv ----
module pib_sync
#(
    parameter int         W    = 1,
    parameter logic [W-1:0] INIT = '0
)
(
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage1;

    // Stage one feeds only stage two
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            stage1 <= INIT;
            dout   <= INIT;
        end
        else
        begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule : pib_sync
